// ==== dspalu_pkg.sv ====
/*
 * Shared constants for the arithmetic datapath: register offsets, control
 * and flag field positions, reset values, command fields and opcodes.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package dspalu_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_FLAGS   = 8'h04;
	localparam logic [7:0] OFF_CMD     = 8'h08;
	localparam logic [7:0] OFF_MEMOP   = 8'h0c;
	localparam logic [7:0] OFF_RESULT  = 8'h10;
	localparam logic [7:0] OFF_RESHI   = 8'h14;
	localparam logic [7:0] OFF_ACCUMULATOR_A_LO = 8'h18;
	localparam logic [7:0] OFF_ACCUMULATOR_A_HI = 8'h1c;
	localparam logic [7:0] OFF_ACCUMULATOR_B_LO = 8'h20;
	localparam logic [7:0] OFF_ACCUMULATOR_B_HI = 8'h24;
	localparam logic [7:0] OFF_WBDATA  = 8'h28;
	localparam logic [7:0] OFF_STATUS  = 8'h2c;
	localparam logic [7:0] OFF_WREG    = 8'h40;

	// core_control_word fields
	localparam int CC_US_LO  = 12;
	localparam int CC_ACC_A_CLAMP_EN   = 7;
	localparam int CC_ACC_B_CLAMP_EN   = 6;
	localparam int CC_MEM_WRITE_CLAMP_EN  = 5;
	localparam int CC_CLAMP_WIDTH_SELECT = 4;
	localparam int CC_RND    = 1;
	localparam int CC_IF     = 0;
	localparam logic [15:0] CC_RESET = 16'h0020;
	localparam logic [15:0] CC_WMASK = 16'h30f3;

	// multiply_sign_select codes
	localparam logic [1:0] US_SIGNED   = 2'h0;
	localparam logic [1:0] US_UNSIGNED = 2'h1;
	localparam logic [1:0] US_MIXED    = 2'h2;

	// cpu_flag_word fields
	localparam int FL_OA  = 15;
	localparam int FL_OB  = 14;
	localparam int FL_SA  = 13;
	localparam int FL_SB  = 12;
	localparam int FL_OAB = 11;
	localparam int FL_SAB = 10;
	localparam int FL_DC  = 8;
	localparam int FL_N   = 3;
	localparam int FL_OV  = 2;
	localparam int FL_Z   = 1;
	localparam int FL_C   = 0;

	// Command word fields
	localparam int CMD_BYTE  = 6;
	localparam int CMD_ACCUMULATOR_B  = 7;
	localparam int CMD_SRC1  = 8;
	localparam int CMD_SRC2  = 12;
	localparam int CMD_DST   = 16;
	localparam int CMD_MSRC  = 20;
	localparam int CMD_MDST  = 21;
	localparam int CMD_LIT   = 22;
	localparam int CMD_DSGN  = 27;
	localparam int CMD_DWIDE = 28;

	localparam int DIV_STEPS = 16;

	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_LSR, OP_ASR,
		OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_SLIT, OP_MUL_ULIT,
		OP_MUL_BB, OP_DIV,
		OP_ACC_CLEAR, OP_SQ_DIFF, OP_SQ_DIFF_ACC, OP_MULT_ACC, OP_SQ_ACC,
		OP_PREFETCH_STORE, OP_PRODUCT, OP_SQUARE, OP_NEG_PRODUCT, OP_MULT_SUB,
		OP_ACC_ADD, OP_ACC_SUB, OP_ACC_NEG, OP_ACC_SHIFT
	} dspalu_op_t;
endpackage : dspalu_pkg

// ==== dspalu_divider.sv ====
/*
 * Iterative restoring divider, one quotient bit per clock.
 * Assumes the caller holds start for one cycle and waits for done.
 */
`timescale 1ns/10ps
module dspalu_divider
	import dspalu_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        start,
	input  wire logic        is_signed,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	output logic             busy,
	output logic             done,
	output logic [15:0]      quotient,
	output logic [15:0]      remainder
);
	typedef enum logic [1:0] {DV_IDLE, DV_RUN, DV_FIX} dspalu_dv_t;

	dspalu_dv_t  st_r;
	logic [4:0]  cnt_r;
	logic [15:0] rem_r;
	logic [15:0] q_r;
	logic [15:0] dv_r;
	logic        qneg_r;
	logic        rneg_r;

	wire         dd_neg   = is_signed & dividend[31];
	wire         dv_neg   = is_signed & divisor[15];
	wire [31:0]  dd_mag   = dd_neg ? 32'(-dividend) : dividend;
	wire [15:0]  dv_mag   = dv_neg ? 16'(-divisor) : divisor;
	wire [16:0]  shl      = {rem_r, q_r[15]};
	wire [17:0]  diff     = {1'b0, shl} - {2'h0, dv_r};
	wire         fits     = ~diff[17];
	wire [15:0]  rem_step = fits ? diff[15:0] : shl[15:0];

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			st_r      <= DV_IDLE;
			cnt_r     <= 5'h00;
			rem_r     <= 16'h0000;
			q_r       <= 16'h0000;
			dv_r      <= 16'h0000;
			qneg_r    <= 1'b0;
			rneg_r    <= 1'b0;
			done      <= 1'b0;
			quotient  <= 16'h0000;
			remainder <= 16'h0000;
		end
		else
		begin
			done <= 1'b0;
			unique case (st_r)
				DV_IDLE:
					if (start)
					begin
						rem_r  <= dd_mag[31:16];
						q_r    <= dd_mag[15:0];
						dv_r   <= dv_mag;
						qneg_r <= dd_neg ^ dv_neg;
						rneg_r <= dd_neg;
						cnt_r  <= 5'h00;
						st_r   <= DV_RUN;
					end
				DV_RUN:
				begin
					// One quotient bit per clock, so both widths take equal time
					rem_r <= rem_step;
					q_r   <= {q_r[14:0], fits};
					cnt_r <= 5'(cnt_r + 5'h01);
					if (cnt_r == 5'(DIV_STEPS - 1))
						st_r <= DV_FIX;
				end
				DV_FIX:
				begin
					quotient  <= qneg_r ? 16'(-q_r) : q_r;
					remainder <= rneg_r ? 16'(-rem_r) : rem_r;
					done      <= 1'b1;
					st_r      <= DV_IDLE;
				end
			endcase
		end
	end

	assign busy = (st_r != DV_IDLE);
endmodule : dspalu_divider

// ==== dspalu_top.sv ====
/*
 * Integer ALU, MCU multiplier, divider and DSP accumulator engine behind
 * an APB slave. Assumes a single clock and a master that waits on pready.
 */
`timescale 1ns/10ps
module dspalu_top
	import dspalu_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr
);
	import dspalu_pkg::*;

	function automatic logic signed [33:0] mul17(input logic signed [16:0] a,
		input logic signed [16:0] b);
		return a * b;
	endfunction : mul17

	function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
		return {sgn & v[15], v};
	endfunction : ext17

	logic [15:0] core_control_word_r;
	logic [15:0] cpu_flag_word_r;
	logic [31:0] cmd_r;
	logic        exec_r;
	logic [15:0] memop_r;
	logic [15:0] result_r;
	logic [15:0] reshi_r;
	logic [39:0] accumulator_a_r;
	logic [39:0] accumulator_b_r;
	logic [15:0] wbdata_r;
	logic [15:0] wreg_r [16];
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        div_busy;
	logic        div_done;
	logic [15:0] div_q;
	logic [15:0] div_r;

	// APB decode; a request completes at the edge where pready is high
	wire         setup_wait = psel & penable & ~pready_r;
	wire         commit     = psel & penable & pready_r;
	wire         wr_commit  = commit & pwrite;
	wire         is_wreg    = (paddr[7:6] == 2'h1) && (paddr[1:0] == 2'h0);
	wire [3:0]   wreg_idx   = paddr[5:2];
	wire         hit_fixed  = (paddr[1:0] == 2'h0) && (paddr <= OFF_STATUS);
	wire         addr_ok    = hit_fixed | is_wreg;
	wire         busy_any   = exec_r | div_busy;
	wire         cmd_write  = wr_commit && (paddr == OFF_CMD) && !busy_any;

	// Command fields
	wire dspalu_op_t op     = dspalu_op_t'(cmd_r[5:0]);
	wire         byte_mode  = cmd_r[CMD_BYTE];
	wire         use_b      = cmd_r[CMD_ACCUMULATOR_B];
	wire [3:0]   src1       = cmd_r[CMD_SRC1 +: 4];
	wire [3:0]   src2       = cmd_r[CMD_SRC2 +: 4];
	wire [3:0]   dst        = cmd_r[CMD_DST +: 4];
	wire [4:0]   lit5       = cmd_r[CMD_LIT +: 5];
	wire         div_sgn    = cmd_r[CMD_DSGN];
	wire         div_wide   = cmd_r[CMD_DWIDE];

	// Core control settings
	wire [1:0]   us_sel     = core_control_word_r[CC_US_LO +: 2];
	wire         sat_a_en   = core_control_word_r[CC_ACC_A_CLAMP_EN];
	wire         sat_b_en   = core_control_word_r[CC_ACC_B_CLAMP_EN];
	wire         sat_mem_en = core_control_word_r[CC_MEM_WRITE_CLAMP_EN];
	wire         super_sat  = core_control_word_r[CC_CLAMP_WIDTH_SELECT];
	wire         rnd_biased = core_control_word_r[CC_RND];
	wire         int_mode   = core_control_word_r[CC_IF];

	// ALU operands: first from register or memory operand
	wire [15:0]  opa        = cmd_r[CMD_MSRC] ? memop_r : wreg_r[src1];
	wire [15:0]  opb        = wreg_r[src2];
	wire         is_sub     = (op == OP_SUB);
	wire [15:0]  opb_eff    = is_sub ? ~opb : opb;
	wire [16:0]  sum_w      = 17'(opa + opb_eff + {15'h0000, is_sub});
	wire [8:0]   sum_b      = 9'(opa[7:0] + opb_eff[7:0] + {7'h00, is_sub});
	wire [4:0]   sum_n      = 5'(opa[3:0] + opb_eff[3:0] + {3'h0, is_sub});
	wire [15:0]  shl_r      = {opa[14:0], 1'b0};
	wire [15:0]  lsr_w      = {1'b0, opa[15:1]};
	wire [15:0]  asr_w      = {opa[15], opa[15:1]};
	wire [15:0]  lsr_b      = {8'h00, 1'b0, opa[7:1]};
	wire [15:0]  asr_b      = {8'h00, opa[7], opa[7:1]};
	wire [15:0]  alu_raw    = (op == OP_ADD || op == OP_SUB) ? sum_w[15:0] :
	                          (op == OP_AND) ? (opa & opb) :
	                          (op == OP_IOR) ? (opa | opb) :
	                          (op == OP_XOR) ? (opa ^ opb) :
	                          (op == OP_SHL) ? shl_r :
	                          (op == OP_LSR) ? (byte_mode ? lsr_b : lsr_w) :
	                          (byte_mode ? asr_b : asr_w);
	wire [15:0]  alu_res    = byte_mode ? {8'h00, alu_raw[7:0]} : alu_raw;
	wire         res_msb    = byte_mode ? alu_res[7] : alu_res[15];
	wire         a_msb      = byte_mode ? opa[7] : opa[15];
	wire         b_msb      = byte_mode ? opb_eff[7] : opb_eff[15];
	wire         arith      = (op == OP_ADD) || is_sub;
	wire         shift_op   = (op == OP_SHL) || (op == OP_LSR) || (op == OP_ASR);
	// Carry out of the top bit; on subtract it is the inverted borrow
	wire         fl_c_arith = byte_mode ? sum_b[8] : sum_w[16];
	wire         fl_c_shift = (op == OP_SHL) ? a_msb : opa[0];
	// Half carry from bit 3 in byte mode, bit 7 in word mode
	wire         fl_dc      = byte_mode ? sum_n[4] : sum_b[8];
	wire         fl_ov      = (a_msb == b_msb) && (res_msb != a_msb);
	wire         fl_z       = byte_mode ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
	wire         is_alu     = (op >= OP_ADD) && (op <= OP_ASR);

	// MCU multiplier: its own 17x17 product through mul17, apart from the DSP one
	wire         m_as       = (op == OP_MUL_SS) || (op == OP_MUL_SU) || (op == OP_MUL_SLIT);
	wire         m_bs       = (op == OP_MUL_SS) || (op == OP_MUL_US);
	wire         m_lit      = (op == OP_MUL_SLIT) || (op == OP_MUL_ULIT);
	wire         m_byte     = (op == OP_MUL_BB);
	wire [15:0]  m_a        = m_byte ? {8'h00, opa[7:0]} : opa;
	wire [15:0]  m_b        = m_lit ? {11'h000, lit5} :
	                          m_byte ? {8'h00, opb[7:0]} : opb;
	wire [33:0]  mcu_prod   = mul17(ext17(m_a, m_as), ext17(m_b, m_bs & ~m_lit));
	wire         is_mul     = (op >= OP_MUL_SS) && (op <= OP_MUL_BB);

	// Divider operands: even-aligned pair, odd register holds upper half
	wire [3:0]   pair_lo    = {src1[3:1], 1'b0};
	wire [3:0]   pair_hi    = {src1[3:1], 1'b1};
	wire [15:0]  dd_lo      = wreg_r[pair_lo];
	wire [31:0]  dd_val     = div_wide ? {wreg_r[pair_hi], dd_lo} :
	                          {{16{div_sgn & dd_lo[15]}}, dd_lo};
	wire         div_start  = exec_r && (op == OP_DIV);

	// DSP multiplier: sign and integer/fraction from core control
	wire         x_sgn      = (us_sel == US_SIGNED) || (us_sel == US_MIXED);
	wire         y_sgn      = (us_sel == US_SIGNED);
	wire [15:0]  dx         = wreg_r[src1];
	wire [15:0]  dy         = wreg_r[src2];
	wire [16:0]  dxe        = ext17(dx, x_sgn);
	wire [16:0]  dye        = ext17(dy, y_sgn);
	wire         is_sqd     = (op == OP_SQ_DIFF) || (op == OP_SQ_DIFF_ACC);
	wire         is_sq      = (op == OP_SQ_ACC) || (op == OP_SQUARE);
	wire [16:0]  sq_d       = 17'({dx[15], dx} - {dy[15], dy});
	wire [16:0]  mx         = is_sqd ? sq_d : dxe;
	wire [16:0]  my         = is_sqd ? sq_d : (is_sq ? dxe : dye);
	wire [33:0]  dsp_raw    = mul17(mx, my);
	wire [33:0]  dsp_prod   = int_mode ? dsp_raw : {dsp_raw[32:0], 1'b0};
	wire [40:0]  prod41     = {{7{dsp_prod[33]}}, dsp_prod};

	// 40-bit adder/subtracter and barrel shifter
	wire [39:0]  tgt        = use_b ? accumulator_b_r : accumulator_a_r;
	wire [39:0]  oth        = use_b ? accumulator_a_r : accumulator_b_r;
	wire [40:0]  tgt41      = {tgt[39], tgt};
	wire [40:0]  oth41      = {oth[39], oth};
	wire signed [5:0] sh_amt = dy[5:0];
	wire [5:0]   sh_mag     = sh_amt[5] ? 6'(-sh_amt) : sh_amt;
	wire [40:0]  shifted    = sh_amt[5] ? 41'(tgt41 << sh_mag) :
	                          41'($signed(tgt41) >>> sh_mag);
	logic [40:0] acc_sum;
	always_comb
	begin
		unique case (op)
			OP_SQ_DIFF, OP_PRODUCT,
			OP_SQUARE:         acc_sum = prod41;
			OP_SQ_DIFF_ACC, OP_MULT_ACC,
			OP_SQ_ACC:         acc_sum = 41'(tgt41 + prod41);
			OP_NEG_PRODUCT:    acc_sum = 41'(-prod41);
			OP_MULT_SUB:       acc_sum = 41'(tgt41 - prod41);
			OP_ACC_ADD:        acc_sum = 41'(tgt41 + oth41);
			OP_ACC_SUB:        acc_sum = 41'(tgt41 - oth41);
			OP_ACC_NEG:        acc_sum = 41'(-tgt41);
			OP_ACC_SHIFT:      acc_sum = shifted;
			OP_PREFETCH_STORE: acc_sum = tgt41;
			default:           acc_sum = 41'h000_0000_0000;
		endcase
	end

	// Accumulator clamp: 9.31 guards 40 bits, 1.31 guards 32 bits
	wire         ovf40      = (acc_sum[40] != acc_sum[39]);
	wire         ovf32      = (acc_sum[40:31] != {10{acc_sum[40]}});
	wire         clamp_en   = use_b ? sat_b_en : sat_a_en;
	wire         clamp_hit  = clamp_en && (super_sat ? ovf40 : ovf32);
	wire [39:0]  lim_pos    = super_sat ? 40'h7f_ffff_ffff : 40'h00_7fff_ffff;
	wire [39:0]  lim_neg    = super_sat ? 40'h80_0000_0000 : 40'hff_8000_0000;
	wire [39:0]  acc_new    = !clamp_hit ? acc_sum[39:0] :
	                          (acc_sum[40] ? lim_neg : lim_pos);
	wire         is_dsp     = (op >= OP_SQ_DIFF) && (op <= OP_ACC_SHIFT) &&
	                          (op != OP_PREFETCH_STORE);

	// Writeback of the other accumulator: round to upper word, then clamp
	wire [15:0]  wb_low     = oth[15:0];
	wire [23:0]  wb_up      = oth[39:16];
	wire         wb_inc     = wb_low[15] & (rnd_biased | (|wb_low[14:0]) | wb_up[0]);
	wire [23:0]  wb_rnd     = 24'(wb_up + {23'h000000, wb_inc});
	wire         wb_ovf     = (wb_rnd[23:15] != {9{wb_rnd[23]}});
	wire [15:0]  wb_val     = (sat_mem_en && wb_ovf) ?
	                          (wb_rnd[23] ? 16'h8000 : 16'h7fff) : wb_rnd[15:0];
	wire         do_wb      = (op == OP_ACC_CLEAR) || (op == OP_MULT_ACC) ||
	                          (op == OP_PREFETCH_STORE) || (op == OP_MULT_SUB);

	// Read data
	wire [31:0]  flags_rd   = {16'h0000, cpu_flag_word_r[15:12],
	                          cpu_flag_word_r[FL_OA] | cpu_flag_word_r[FL_OB],
	                          cpu_flag_word_r[FL_SA] | cpu_flag_word_r[FL_SB],
	                          cpu_flag_word_r[9:0]};
	wire [31:0]  rd_mux     = is_wreg                  ? {16'h0000, wreg_r[wreg_idx]} :
	                          (paddr == OFF_CTRL)      ? {16'h0000, core_control_word_r} :
	                          (paddr == OFF_FLAGS)     ? flags_rd :
	                          (paddr == OFF_CMD)       ? cmd_r :
	                          (paddr == OFF_MEMOP)     ? {16'h0000, memop_r} :
	                          (paddr == OFF_RESULT)    ? {16'h0000, result_r} :
	                          (paddr == OFF_RESHI)     ? {16'h0000, reshi_r} :
	                          (paddr == OFF_ACCUMULATOR_A_LO)   ? accumulator_a_r[31:0] :
	                          (paddr == OFF_ACCUMULATOR_A_HI)   ? {24'h000000, accumulator_a_r[39:32]} :
	                          (paddr == OFF_ACCUMULATOR_B_LO)   ? accumulator_b_r[31:0] :
	                          (paddr == OFF_ACCUMULATOR_B_HI)   ? {24'h000000, accumulator_b_r[39:32]} :
	                          (paddr == OFF_WBDATA)    ? {16'h0000, wbdata_r} :
	                          (paddr == OFF_STATUS)    ? {31'h00000000, busy_any} :
	                          32'h0000_0000;

	// Flag word update; hardware sets win over a software clear
	wire         sat_set_a  = exec_r && is_dsp && !use_b && clamp_hit;
	wire         sat_set_b  = exec_r && is_dsp && use_b && clamp_hit;
	wire         flag_wr    = wr_commit && (paddr == OFF_FLAGS);
	wire [15:0]  sw_flags   = pwdata[15:0];
	wire         sab_clear  = flag_wr && !sw_flags[FL_SAB];
	wire         sa_keep    = flag_wr ? (sw_flags[FL_SA] & !sab_clear) : cpu_flag_word_r[FL_SA];
	wire         sb_keep    = flag_wr ? (sw_flags[FL_SB] & !sab_clear) : cpu_flag_word_r[FL_SB];
	wire [39:0]  a_next     = (exec_r && is_dsp && !use_b) ? acc_new : accumulator_a_r;
	wire [39:0]  b_next     = (exec_r && is_dsp && use_b) ? acc_new : accumulator_b_r;
	wire         oa_nxt     = (a_next[39:31] != {9{a_next[39]}});
	wire         ob_nxt     = (b_next[39:31] != {9{b_next[39]}});
	logic [9:0]  mcu_fl_nxt;
	always_comb
	begin
		mcu_fl_nxt = flag_wr ? sw_flags[9:0] : cpu_flag_word_r[9:0];
		if (exec_r && is_alu)
		begin
			mcu_fl_nxt[FL_N] = res_msb;
			mcu_fl_nxt[FL_Z] = fl_z;
			if (arith)
			begin
				mcu_fl_nxt[FL_C]  = fl_c_arith;
				mcu_fl_nxt[FL_DC] = fl_dc;
				mcu_fl_nxt[FL_OV] = fl_ov;
			end
			else if (shift_op)
				mcu_fl_nxt[FL_C] = fl_c_shift;
		end
	end
	wire [15:0]  cpu_flag_word_nxt = {oa_nxt, ob_nxt, sa_keep | sat_set_a, sb_keep | sat_set_b,
	                                  2'h0, mcu_fl_nxt};

	dspalu_divider u_div (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.start     (div_start),
		.is_signed (div_sgn),
		.dividend  (dd_val),
		.divisor   (wreg_r[src2]),
		.busy      (div_busy),
		.done      (div_done),
		.quotient  (div_q),
		.remainder (div_r)
	);

	// APB handshake: one wait state, then data and pready together
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r  <= setup_wait;
			prdata_r  <= setup_wait ? rd_mux : 32'h0000_0000;
			pslverr_r <= setup_wait & ~addr_ok;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			core_control_word_r <= CC_RESET;
			cpu_flag_word_r     <= 16'h0000;
			cmd_r               <= 32'h0000_0000;
			exec_r              <= 1'b0;
			memop_r             <= 16'h0000;
		end
		else
		begin
			if (wr_commit && (paddr == OFF_CTRL))
				core_control_word_r <= pwdata[15:0] & CC_WMASK;
			if (wr_commit && (paddr == OFF_MEMOP))
				memop_r <= pwdata[15:0];
			if (cmd_write)
				cmd_r <= pwdata;
			exec_r          <= cmd_write;
			cpu_flag_word_r <= cpu_flag_word_nxt;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			accumulator_a_r <= 40'h00_0000_0000;
			accumulator_b_r <= 40'h00_0000_0000;
			wbdata_r        <= 16'h0000;
			result_r        <= 16'h0000;
			reshi_r         <= 16'h0000;
		end
		else
		begin
			// Clear loads zero into the target here directly, not through the DSP sum
			accumulator_a_r <= (exec_r && (op == OP_ACC_CLEAR) && !use_b) ? 40'h00_0000_0000 : a_next;
			accumulator_b_r <= (exec_r && (op == OP_ACC_CLEAR) && use_b) ? 40'h00_0000_0000 : b_next;
			if (exec_r && do_wb)
				wbdata_r <= wb_val;
			if (exec_r && is_alu)
				result_r <= alu_res;
			else if (exec_r && is_mul)
			begin
				result_r <= mcu_prod[15:0];
				reshi_r  <= mcu_prod[31:16];
			end
			else if (div_done)
			begin
				result_r <= div_q;
				reshi_r  <= div_r;
			end
		end
	end

	// Working registers; byte results leave the upper byte untouched
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < 16; i++)
				wreg_r[i] <= 16'h0000;
		end
		else if (div_done)
		begin
			wreg_r[0] <= div_q;
			wreg_r[1] <= div_r;
		end
		else if (exec_r && is_alu && !cmd_r[CMD_MDST])
			wreg_r[dst] <= byte_mode ? {wreg_r[dst][15:8], alu_res[7:0]} : alu_res;
		else if (exec_r && is_mul && !cmd_r[CMD_MDST])
		begin
			wreg_r[{dst[3:1], 1'b0}] <= mcu_prod[15:0];
			wreg_r[{dst[3:1], 1'b1}] <= mcu_prod[31:16];
		end
		else if (exec_r && do_wb && !cmd_r[CMD_MDST])
			wreg_r[dst] <= wb_val;
		else if (wr_commit && is_wreg)
			wreg_r[wreg_idx] <= pwdata[15:0];
	end

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
endmodule : dspalu_top

// ==== dspalu_top_sva.sv ====
/* APB port checker for dspalu_top.
   Assumes one wait state per access and a bind at the foot. */
`timescale 1ns/10ps
module dspalu_top_sva (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire acc_w = psel && penable && !pready;
	// Gap between status and working registers
	wire hole_w = paddr >= 8'h30 && paddr < 8'h40;
	AST_ONE_WAIT: assert property (acc_w |=> pready)
		else $error("no ready after access");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready held");
	AST_CAUSE: assert property (pready |-> $past(acc_w))
		else $error("ready without access");
	AST_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("outputs not idle");
	AST_HOLE_ERR: assert property (acc_w && hole_w |=> pslverr)
		else $error("no error on gap");
	AST_MAP_OK: assert property (acc_w && paddr < 8'h30 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("error on mapped word");
	AST_CTRL_BITS: assert property (acc_w && !pwrite && paddr == 8'h00 |=>
		(prdata & 32'hffffcf0c) == 32'h0) else $error("control spare bits set");
	AST_STAT_BITS: assert property (acc_w && !pwrite && paddr == 8'h2c |=>
		prdata[31:1] == 31'h0) else $error("status spare bits set");
endmodule : dspalu_top_sva
bind dspalu_top dspalu_top_sva dspalu_top_sva_inst (.ref_clk(ref_clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.prdata(prdata), .pslverr(pslverr));

// ==== dspalu_cpu_model.sv ====
/* CPU side model: APB master issuing register accesses.
   Assumes the bench bounds every wait on pready. */
`timescale 1ns/10ps
module dspalu_cpu_model (
	input  wire logic        ref_clk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// Starts one edge after the last release, so no signal is driven twice per step
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : dspalu_cpu_model

// ==== dspalu_top_tb_top.sv ====
/* Self-checking bench: ALU, multiply, divide and accumulator sequences.
   Assumes a 200 MHz clock and the CPU model as master. */
`timescale 1ns/10ps
module dspalu_top_tb_top;
	import dspalu_pkg::*;
	logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, rd_e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_q;
	int          n_mismatch = 0, n_tests = 0, cyc = 0, t0, t1;
	dspalu_op_t  mop [7] = '{OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_SLIT,
		OP_MUL_ULIT, OP_MUL_BB};
	logic [31:0] mexp [7] = '{32'hfffffffe, 32'h1fffe, 32'hfffffffe, 32'h1fffe,
		32'hffffffe1, 32'h1effe1, 32'h1fe};
	dspalu_top dspalu_top_inst (.ref_clk(ref_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	dspalu_cpu_model dspalu_cpu_model_inst (.ref_clk(ref_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task test_done;
		$display("mismatches %0d compares %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		dspalu_cpu_model_inst.xfer(1'b1, a, d, rd_q, rd_e);
	endtask : wr
	task rc(input logic [7:0] a, input logic [31:0] exp);
		dspalu_cpu_model_inst.xfer(1'b0, a, 32'h0, rd_q, rd_e);
		chk(rd_q, exp);
	endtask : rc
	// Polls busy so a divide never sees a second command
	task op(input logic [31:0] c);
		wr(OFF_CMD, c);
		t0 = 0;
		do
		begin
			dspalu_cpu_model_inst.xfer(1'b0, OFF_STATUS, 32'h0, rd_q, rd_e);
			t0++;
		end
		while (rd_q[0] !== 1'b0);
	endtask : op
	function automatic logic [31:0] cm(input dspalu_op_t o, input int s1, s2, d);
		return {12'h0, 4'(d), 4'(s2), 4'(s1), 2'h0, o};
	endfunction : cm
	initial
	begin
		reset = 1'b1;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		rc(OFF_CTRL, 32'h20);
		rc(8'h30, 32'h0);
		chk({31'h0, rd_e}, 32'h1);
		wr(OFF_WREG + 8'h04, 32'h7fff);
		wr(OFF_WREG + 8'h08, 32'h1);
		op(cm(OP_ADD, 1, 2, 3));
		rc(OFF_WREG + 8'h0c, 32'h8000);
		rc(OFF_FLAGS, 32'h10c);
		op(cm(OP_SUB, 1, 1, 3));
		rc(OFF_FLAGS, 32'h103);
		wr(OFF_WREG + 8'h10, 32'h12ff);
		op(cm(OP_ADD, 4, 2, 4) | 32'h40);
		rc(OFF_WREG + 8'h10, 32'h1200);
		$display("alu test done");
		wr(OFF_WREG + 8'h04, 32'hffff);
		wr(OFF_WREG + 8'h08, 32'h2);
		for (int i = 0; i < 7; i++)
		begin
			op(cm(mop[i], 1, 2, 6) | 32'h07c00000);
			rc(OFF_WREG + 8'h18, {16'h0, mexp[i][15:0]});
			rc(OFF_WREG + 8'h1c, {16'h0, mexp[i][31:16]});
		end
		$display("mul test done");
		wr(OFF_WREG + 8'h18, 32'h7);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFF_WREG + 8'h10, i == 0 ? 32'h64 : i == 1 ? 32'h0 : 32'hff9c);
			wr(OFF_WREG + 8'h14, {31'h0, i == 1});
			op(cm(OP_DIV, 4, 6, 0) | (i == 1 ? 32'h10000000 : i == 2 ? 32'h08000000 : 0));
			if (i == 0)
				t1 = t0;
			chk(32'(t0), 32'(t1));
			rc(OFF_WREG, i == 0 ? 32'he : i == 1 ? 32'h2492 : 32'hfff2);
			rc(OFF_WREG + 8'h04, i == 2 ? 32'hfffe : 32'h2);
		end
		$display("div test done");
		wr(OFF_WREG + 8'h04, 32'h3);
		wr(OFF_WREG + 8'h08, 32'h2);
		wr(OFF_CTRL, 32'h21);
		op(cm(OP_PRODUCT, 1, 2, 9));
		rc(OFF_ACCUMULATOR_A_LO, 32'h6);
		wr(OFF_CTRL, 32'h20);
		op(cm(OP_PRODUCT, 1, 2, 9));
		op(cm(OP_ACC_NEG, 0, 0, 9));
		rc(OFF_ACCUMULATOR_A_LO, 32'hfffffff4);
		rc(OFF_ACCUMULATOR_A_HI, 32'hff);
		// Shift left by 30 overflows 1.31, so the clamp must hold the negative limit
		wr(OFF_CTRL, 32'ha0);
		wr(OFF_WREG + 8'h0c, 32'h22);
		op(cm(OP_ACC_SHIFT, 0, 3, 9));
		rc(OFF_ACCUMULATOR_A_LO, 32'h80000000);
		rc(OFF_ACCUMULATOR_A_HI, 32'hff);
		rc(OFF_FLAGS, 32'h2503);
		wr(OFF_FLAGS, 32'h0);
		rc(OFF_FLAGS, 32'h0);
		wr(OFF_WREG + 8'h24, 32'h5555);
		op(cm(OP_ACC_CLEAR, 0, 0, 9));
		rc(OFF_ACCUMULATOR_A_LO, 32'h0);
		rc(OFF_WREG + 8'h24, 32'h0);
		// Half-way low word: biased rounds up, convergent keeps the even value
		wr(OFF_WREG + 8'h14, 32'h4000);
		wr(OFF_CTRL, 32'h23);
		op(cm(OP_PRODUCT, 5, 2, 9));
		op(cm(OP_PREFETCH_STORE, 0, 0, 10) | 32'h80);
		rc(OFF_WBDATA, 32'h1);
		wr(OFF_CTRL, 32'h21);
		op(cm(OP_PREFETCH_STORE, 0, 0, 10) | 32'h80);
		rc(OFF_WBDATA, 32'h0);
		wr(OFF_WREG + 8'h04, 32'hffff);
		wr(OFF_CTRL, 32'h2021);
		op(cm(OP_PRODUCT, 1, 1, 9));
		rc(OFF_ACCUMULATOR_A_LO, 32'hffff0001);
		rc(OFF_ACCUMULATOR_A_HI, 32'hff);
		wr(OFF_MEMOP, 32'h5);
		op(cm(OP_ADD, 0, 2, 11) | 32'h100000);
		rc(OFF_WREG + 8'h2c, 32'h7);
		$display("dsp test done");
		test_done();
	end
endmodule : dspalu_top_tb_top
